// [rtl/nml_consts.vh]
/*
  Constants for the normalize and shift-count-load extension control.
  Assumes a 12-bit host word, bit 00 the most significant, and a 25 MHz clock.
*/
`ifndef NML_CONSTS_VH
`define NML_CONSTS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define NML_W 12
`define NML_TW 5
`define NML_OPW 3

// ----------------------------------------
// Opcodes and instruction bit positions (bit 00 is the leftmost)
// ----------------------------------------
`define NML_OP_ALREADY_ALIGNED 12'o7411
`define NML_OP_SCL 12'o7403
`define NML_MB03 8
`define NML_MB09 2
`define NML_MB10 1
`define NML_MB11 0
`define NML_IR_HI 3
`define NML_IR_LO 1
`define NML_CNT_HI 4
`define NML_CNT_LO 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define NML_CLK_NS 40
`define NML_TP_NS 450
`define NML_TG_NS 100
`define NML_TP_CYC (`NML_TP_NS / `NML_CLK_NS)
`define NML_TG_CYC ((`NML_TG_NS + `NML_CLK_NS - 1) / `NML_CLK_NS)
`define NML_DIVW 4
`define NML_DIV_ZERO 4'h0
`define NML_TALLY_ZERO 5'h00
`define NML_TALLY_ONE 5'h01

`endif

// [rtl/nml_tally.v]
/*
  Five-bit shift tally with lookahead increment and ones-complement load.
  Assumes its strobes come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "nml_consts.vh"
module nml_tally (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire clear_i,
  input wire incr_i,
  input wire load_i,
  input wire [`NML_TW-1:0] load_val_i,
  output wire [`NML_TW-1:0] tally_o
);

  reg [`NML_TW-1:0] tally_reg;
  reg [`NML_TW-1:0] tally_next;

  // Each bit toggles when every lower bit is one, like the gate tree it replaces.
  function [`NML_TW-1:0] nml_incr;
    input [`NML_TW-1:0] v;
    integer k;
    reg all_ones;
    begin
      all_ones = 1'b1;
      for (k = 0; k < `NML_TW; k = k + 1) begin
        nml_incr[k] = v[k] ^ all_ones;
        all_ones = all_ones & v[k];
      end
    end
  endfunction

  always @* begin
    tally_next = tally_reg;
    if (clear_i) begin
      tally_next = `NML_TALLY_ZERO;
    end else if (load_i) begin
      tally_next = ~load_val_i;
    end else if (incr_i) begin
      tally_next = nml_incr(tally_reg);
    end
  end

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      tally_reg <= `NML_TALLY_ZERO;
    end else begin
      tally_reg <= tally_next;
    end
  end

  assign tally_o = tally_reg;

endmodule

// [rtl/nml_ctrl.v]
/*
  Control for the normalize and shift-count-load extension instructions.
  Assumes the host sequencer drives fetch/execute levels and its time pulses on
  this clock, honours the pause request, and does the address transfers requested.
*/
`timescale 1ns/1ns
`include "nml_consts.vh"
module nml_ctrl (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire fetch_i,
  input wire execute_i,
  input wire operate_group_i,
  input wire fetch_pulse_three_i,
  input wire fetch_pulse_four_i,
  input wire fetch_entry_i,
  input wire multiply_op_i,
  input wire divide_op_i,
  input wire [`NML_W-1:0] memory_buffer_i,
  input wire [`NML_W-1:0] work_load_i,
  input wire [`NML_W-1:0] quot_load_i,
  input wire reg_load_i,
  output wire ext_op_decoded_o,
  output wire ext_exec_set_o,
  output wire pc_to_ma_en_o,
  output wire execute_entry_o,
  output wire pc_increment_o,
  output wire buffer_to_counter_en_o,
  output wire ext_go_request_o,
  output wire ext_kickoff_o,
  output wire host_pause_o,
  output wire already_aligned_o,
  output wire ext_timing_pulse_o,
  output wire ext_timing_gate_o,
  output wire timed_op_o,
  output wire carry_valid_o,
  output wire [`NML_W-1:0] main_working_reg_o,
  output wire [`NML_W-1:0] product_quotient_ext_o,
  output wire [`NML_TW-1:0] shift_tally_o,
  output wire [`NML_OPW-1:0] ext_op_latch_o
);

  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_LAST = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`NML_W-1:0] work_reg;
  reg [`NML_W-1:0] quot_reg;
  reg [`NML_OPW-1:0] op_reg;
  reg [`NML_DIVW-1:0] div_reg;
  reg gate_low_reg;
  reg tp_reg;
  reg pause_reg;
  reg carry_valid_reg;
  reg quot_pending_reg;

  wire is_already_aligned;
  wire is_scl;
  wire run;
  wire slot;
  wire tp;
  wire aligned;
  wire stop_early;
  wire kick;
  wire [`NML_W-1:0] work_shift;
  wire [`NML_W-1:0] quot_shift;

  // Bit 00 is the most significant: index w-1-n in vector terms.
  function bitn;
    input [`NML_W-1:0] v;
    input integer n;
    begin
      bitn = v[`NML_W-1-n];
    end
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign ext_op_decoded_o = fetch_i & operate_group_i & memory_buffer_i[`NML_MB03] &
    memory_buffer_i[`NML_MB11];
  assign is_already_aligned = (memory_buffer_i == `NML_OP_ALREADY_ALIGNED);
  assign is_scl = (memory_buffer_i == `NML_OP_SCL);
  // Bits 08-10 nonzero with the other extension fields marks a timed op, except the count load.
  assign timed_op_o = ext_op_decoded_o & ~is_scl &
    (memory_buffer_i[`NML_IR_HI:`NML_IR_LO] != 3'h0);

  // ----------------------------------------
  // Aligned test
  // ----------------------------------------
  assign aligned = (bitn(work_reg, 0) ^ bitn(work_reg, 1)) |
    (~bitn(work_reg, 2) & ~bitn(work_reg, 3) & (work_reg[7:0] == 8'h00) &
    (quot_reg == 12'h000));
  assign stop_early = (~bitn(work_reg, 1) & bitn(work_reg, 2)) |
    (~bitn(work_reg, 3) & (work_reg[7:0] == 8'h00) & (quot_reg == 12'h000));
  assign already_aligned_o = aligned;

  assign ext_go_request_o = ext_op_decoded_o & is_already_aligned & ~aligned;
  // Kickoff only from a fetch; count-load execute can never start timing.
  assign kick = ext_go_request_o & fetch_pulse_three_i & state_reg[0] &
    ~execute_i;
  assign ext_kickoff_o = kick;

  // ----------------------------------------
  // Count load path
  // ----------------------------------------
  assign ext_exec_set_o = ext_op_decoded_o & is_scl;
  assign execute_entry_o = ext_exec_set_o & fetch_pulse_four_i;
  assign pc_to_ma_en_o = ext_exec_set_o | (execute_i & fetch_entry_i);
  assign pc_increment_o = execute_i & operate_group_i & state_reg[0];
  assign buffer_to_counter_en_o = execute_i & operate_group_i & state_reg[0] &
    ~multiply_op_i & ~divide_op_i;

  // ----------------------------------------
  // Extension timing generator
  // ----------------------------------------
  assign run = ~state_reg[0];
  assign slot = run & (div_reg == `NML_DIV_ZERO);
  // A slot that finds the word aligned is the lost pulse: it shifts nothing.
  assign tp = slot & state_reg[1] & ~aligned;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (kick) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (slot & (stop_early | aligned)) begin
          state_next = ST_LAST;
        end
      end
      ST_LAST: begin
        if (slot) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Left shift: zero enters quotient bit 11; divide is out of scope here.
  assign work_shift = {work_reg[`NML_W-2:0], bitn(quot_reg, 0)};
  assign quot_shift = {quot_reg[`NML_W-2:0], 1'b0};

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      work_reg <= 12'h000;
      quot_reg <= 12'h000;
      op_reg <= 3'h0;
      div_reg <= `NML_DIV_ZERO;
      gate_low_reg <= 1'b0;
      tp_reg <= 1'b0;
      pause_reg <= 1'b0;
      carry_valid_reg <= 1'b1;
      quot_pending_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tp_reg <= tp;
      if (kick | ~run | (div_reg == (`NML_TP_CYC - 1))) begin
        div_reg <= `NML_DIV_ZERO;
      end else begin
        div_reg <= div_reg + 4'h1;
      end
      gate_low_reg <= tp | (gate_low_reg & (div_reg < `NML_TG_CYC));
      if (kick) begin
        pause_reg <= 1'b1;
      end else if (state_reg[2] & slot) begin
        pause_reg <= 1'b0;
      end
      if (ext_op_decoded_o & fetch_pulse_three_i & state_reg[0]) begin
        op_reg <= memory_buffer_i[`NML_IR_HI:`NML_IR_LO];
      end
      if (kick) begin
        carry_valid_reg <= 1'b0;
      end else if (reg_load_i) begin
        carry_valid_reg <= 1'b1;
      end
      if (tp) begin
        work_reg <= work_shift;
      end else if (reg_load_i & ~run) begin
        work_reg <= work_load_i;
      end
      // Quotient loads in the gate window, so it sees the shift source captured at the pulse.
      if (tp) begin
        quot_pending_reg <= 1'b1;
      end else if (quot_pending_reg) begin
        quot_pending_reg <= 1'b0;
        quot_reg <= quot_shift;
      end else if (reg_load_i & ~run) begin
        quot_reg <= quot_load_i;
      end
    end
  end

  // ----------------------------------------
  // Shift tally
  // ----------------------------------------
  nml_tally u_tally (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .clear_i(ext_op_decoded_o & is_already_aligned & fetch_pulse_three_i & state_reg[0]),
    .incr_i(tp_reg),
    .load_i(buffer_to_counter_en_o & fetch_pulse_three_i),
    .load_val_i(memory_buffer_i[`NML_CNT_HI:`NML_CNT_LO]),
    .tally_o(shift_tally_o)
  );

  assign host_pause_o = pause_reg;
  assign ext_timing_pulse_o = tp;
  assign ext_timing_gate_o = ~gate_low_reg;
  assign carry_valid_o = carry_valid_reg;
  assign main_working_reg_o = work_reg;
  assign product_quotient_ext_o = quot_reg;
  assign ext_op_latch_o = op_reg;

endmodule

// [verif/nml_ctrl_asserts.sv]
/*
  Assertion checker for the normalize and count-load control.
  Assumes it is bound to nml_ctrl and sees only its ports.
*/
`timescale 1ns/1ns
module nml_ctrl_chk (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire fetch_i,
  input wire execute_i,
  input wire operate_group_i,
  input wire fetch_pulse_three_i,
  input wire [11:0] memory_buffer_i,
  input wire ext_op_decoded_o,
  input wire ext_kickoff_o,
  input wire host_pause_o,
  input wire already_aligned_o,
  input wire ext_timing_pulse_o,
  input wire ext_timing_gate_o,
  input wire carry_valid_o,
  input wire buffer_to_counter_en_o,
  input wire [11:0] main_working_reg_o,
  input wire [11:0] product_quotient_ext_o,
  input wire [4:0] shift_tally_o,
  input wire [2:0] ext_op_latch_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  wire [11:0] w = main_working_reg_o;
  wire [11:0] q = product_quotient_ext_o;
  wire [11:0] w_sh = {w[10:0], q[11]};
  wire [11:0] q_sh = {q[10:0], 1'b0};
  wire [4:0] t_inc = shift_tally_o + 5'h01;
  wire [2:0] mb_op = memory_buffer_i[3:1];
  wire [4:0] mb_cnt = memory_buffer_i[4:0];
  wire tp = ext_timing_pulse_o;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_kick;
    fetch_pulse_three_i && ext_kickoff_o;
  endsequence
  sequence s_gate_low;
    !ext_timing_gate_o [*3];
  endsequence
  chk_decode_ext:
    assert property (ext_op_decoded_o == (fetch_i && operate_group_i && memory_buffer_i[8]
      && memory_buffer_i[0])) else $error("decode wrong");
  chk_aligned_test:
    assert property (already_aligned_o == ((w[11] ^ w[10]) || (w[9:0] == 10'h000
      && q == 12'h000))) else $error("aligned wrong");
  chk_kick_cond:
    assert property (ext_kickoff_o |-> fetch_pulse_three_i && !already_aligned_o)
      else $error("kickoff wrong");
  chk_kick_start:
    assert property (s_kick |=> host_pause_o && shift_tally_o == 5'h00 && !carry_valid_o
      && ext_op_latch_o == $past(mb_op)) else $error("start wrong");
  chk_work_shift:
    assert property (tp |=> w == $past(w_sh)) else $error("working shift wrong");
  chk_quot_shift:
    assert property (tp |-> ##2 q == $past(q_sh, 2)) else $error("quotient shift wrong");
  chk_tally_step:
    assert property (tp |-> ##2 shift_tally_o == $past(t_inc, 2)) else $error("tally step");
  chk_gate_low:
    assert property (tp |=> s_gate_low ##1 ext_timing_gate_o) else $error("gate wrong");
  chk_tp_spacing:
    assert property (tp |=> !tp [*8]) else $error("pulse spacing");
  chk_no_kick_exec:
    assert property (execute_i |-> !ext_kickoff_o && !host_pause_o) else $error("exec timing");
  chk_count_load:
    assert property (fetch_pulse_three_i && buffer_to_counter_en_o |=>
      shift_tally_o == ~$past(mb_cnt)) else $error("count load wrong");
  chk_pause_bound:
    assert property ($rose(host_pause_o) |-> ##[1:300] !host_pause_o) else $error("pause stuck");
endmodule
bind nml_ctrl nml_ctrl_chk u_nml_ctrl_chk (.*);

// [verif/nml_host_model.sv]
/*
  Host fetch/execute sequencer model.
  Assumes the bench calls run just after a rising clock edge.
*/
`timescale 1ns/1ns
module nml_host_model (
  input wire clk_i,
  input wire host_pause_i,
  input wire execute_entry_i,
  output reg fetch_o = 1'b0,
  output reg execute_o = 1'b0,
  output reg opr_o = 1'b0,
  output reg tp3_o = 1'b0,
  output reg tp4_o = 1'b0,
  output reg fentry_o = 1'b0,
  output reg [11:0] mb_o = 12'h000
);
  // ----------------------------------------
  // One instruction
  // ----------------------------------------
  task run(input [11:0] i0, input [11:0] i1);
    integer k;
    reg ent;
    begin
      mb_o <= i0;
      opr_o <= 1'b1;
      fetch_o <= 1'b1;
      @(posedge clk_i) tp3_o <= 1'b1;
      @(posedge clk_i) tp3_o <= 1'b0;
      k = 0;
      @(posedge clk_i);
      while (host_pause_i && k < 400) begin
        @(posedge clk_i);
        k = k + 1;
      end
      tp4_o <= 1'b1;
      @(posedge clk_i) ent = execute_entry_i;
      tp4_o <= 1'b0;
      fetch_o <= 1'b0;
      if (ent) begin
        execute_o <= 1'b1;
        mb_o <= i1;
        @(posedge clk_i) tp3_o <= 1'b1;
        @(posedge clk_i) tp3_o <= 1'b0;
        fentry_o <= 1'b1;
        @(posedge clk_i) fentry_o <= 1'b0;
        execute_o <= 1'b0;
      end
      // A released buffer shows no stale word.
      mb_o <= ~mb_o;
      opr_o <= 1'b0;
      @(posedge clk_i);
    end
  endtask
endmodule

// [verif/tb_nml_ctrl.sv]
/*
  Self-checking bench for nml_ctrl.
  Assumes the host model drives the sequencer side.
*/
`timescale 1ns/1ns
`include "nml_consts.vh"
module tb_nml_ctrl;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  reg sys_clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg reg_load_i = 1'b0;
  reg clr = 1'b0;
  reg [11:0] work_load_i = 12'h000;
  reg [11:0] quot_load_i = 12'h000;
  reg [11:0] a, b, c;
  reg [4:0] seen = 5'h00;
  reg [28:0] ex;
  wire [11:0] mb, w, q;
  wire [4:0] t;
  wire f, e, operate_group, tp3, tp4, fe, ee, es, pcma, inc, btc, pz, tg, cv;
  integer error_cnt = 0, checks_done = 0, seed = 28, cyc = 0, n;
  always #20 sys_clk_i = ~sys_clk_i;
  nml_ctrl u_nml_ctrl (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .fetch_i(f),
    .execute_i(e), .operate_group_i(operate_group), .fetch_pulse_three_i(tp3),
    .fetch_pulse_four_i(tp4), .fetch_entry_i(fe), .multiply_op_i(1'b0),
    .divide_op_i(1'b0), .memory_buffer_i(mb), .work_load_i(work_load_i),
    .quot_load_i(quot_load_i), .reg_load_i(reg_load_i), .ext_op_decoded_o(),
    .ext_exec_set_o(es), .pc_to_ma_en_o(pcma), .execute_entry_o(ee),
    .pc_increment_o(inc), .buffer_to_counter_en_o(btc), .ext_go_request_o(),
    .ext_kickoff_o(), .host_pause_o(pz), .already_aligned_o(),
    .ext_timing_pulse_o(), .ext_timing_gate_o(tg), .timed_op_o(),
    .carry_valid_o(cv), .main_working_reg_o(w), .product_quotient_ext_o(q),
    .shift_tally_o(t), .ext_op_latch_o());
  nml_host_model u_nml_host_model (.clk_i(sys_clk_i), .host_pause_i(pz),
    .execute_entry_i(ee), .fetch_o(f), .execute_o(e), .opr_o(operate_group), .tp3_o(tp3),
    .tp4_o(tp4), .fentry_o(fe), .mb_o(mb));
  function [28:0] already_aligned_exp(input [11:0] w0, input [11:0] q0);
    reg [11:0] x, y;
    reg [4:0] k;
    begin
      x = w0;
      y = q0;
      k = 5'h00;
      while (!(x[11] ^ x[10]) && !(x[9:0] == 10'h000 && y == 12'h000)) begin
        x = {x[10:0], y[11]};
        y = {y[10:0], 1'b0};
        k = k + 5'h01;
      end
      already_aligned_exp = {k, x, y};
    end
  endfunction
  task cmp(input [28:0] got, input [28:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      if (error_cnt == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task do_op(input [11:0] i0, input [11:0] i1);
    begin
      clr <= 1'b1;
      @(posedge sys_clk_i) clr <= 1'b0;
      u_nml_host_model.run(i0, i1);
      repeat (2) @(posedge sys_clk_i);
    end
  endtask
  // Flags are sticky so short pulses are never missed between checks.
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
    seen <= clr ? 5'h00 : seen | {es && pcma && ee, e && inc, fe && pcma, e && btc, pz};
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    cmp({22'h0, cv, tg, t}, {22'h0, 7'h60});
    for (n = 0; n < 20; n = n + 1) begin
      a = $random(seed);
      b = $random(seed);
      c = $random(seed);
      if (n < 3) begin
        a = 12'h000;
        b = (n == 0) ? 12'h001 : 12'h000;
      end
      if (n == 2)
        a = 12'h400;
      do_op(`NML_OP_SCL, c);
      cmp({24'h0, seen}, {24'h0, 5'b11110});
      cmp({24'h0, t}, {24'h0, ~c[4:0]});
      work_load_i <= a;
      quot_load_i <= b;
      reg_load_i <= 1'b1;
      @(posedge sys_clk_i) reg_load_i <= 1'b0;
      ex = already_aligned_exp(a, b);
      do_op(`NML_OP_ALREADY_ALIGNED, ~c);
      cmp({t, w, q}, ex);
      cmp({26'h0, seen[2:0]}, {28'h0, ex[28:24] != 5'h00});
      if (ex[28:24] != 5'h00)
        cmp({28'h0, cv}, 29'h0);
    end
    complete_run;
  end
endmodule
